// ---- logic/tmc_config_bank.sv ----
// Purpose: mode control and modem configuration register bank
// Assumes: one-cycle strobes, read data valid the cycle after the read strobe
// Notes: temperature readout comes from the sensor on this clock;
//   a write with a reserved mode code keeps the old target, its other bits land;
//   the divisor has no shadow, so the rate is briefly mixed between byte writes;
//   op_mode trails the internal state by one cycle so it leaves as a clean flop
// How it works
// - with bypass clear, the state steps through intermediate modes to target
// - with bypass set, the written mode is entered at once
// - cancel written with enable cleared aborts listen; cancel reads zero
// - mode field bits 4..2 decode sleep/standby/synth/tx/rx, reset standby
// - mode field reads the actual current state
// - data processing field: packet, sync continuous, plain continuous
// - FSK shaping: none, gaussian BT 1.0, 0.5, 0.3
// - modulation field selects FSK or OOK; OOK shaping filters at rate
// - rate upper register holds divisor bits 15..8, reset 0x1A
// - reset reloads every register with its built-in value
// - rate lower register holds divisor bits 7..0
//
// Chosen here: the strobed register port.
`timescale 1ns/1ps
module tmc_config_bank
  import tmc_pkg::*;
#(
  parameter int STEP_CYC = SEQ_STEP_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [6:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] temp_value,
  input wire logic temp_done,
  output logic [7:0] reg_rdata,
  output logic [2:0] op_mode,
  output logic listen_active,
  output logic listen_cancel_pulse,
  output logic [7:0] fifo_wr_data,
  output logic fifo_wr_pulse,
  output logic temp_start_pulse,
  output tmc_modem_cfg_t modem_cfg,
  output logic [7:0] sensitivity_boost,
  output logic [7:0] high_power_setting_one,
  output logic [7:0] high_power_setting_two,
  output logic [7:0] fading_margin_control,
  output logic [7:0] low_index_freq_offset
);
  initial begin
    if (STEP_CYC < 1 || STEP_CYC > 255) begin
      $error("tmc_config_bank: STEP_CYC out of range");
    end
    // the key window must match the sixteen entries of the key store
    if (int'(OFS_KEY_LAST) - int'(OFS_KEY_FIRST) != 15) begin
      $error("tmc_config_bank: key window size mismatch");
    end
  end

  // one bundle for the register port request
  tmc_req_t req;
  assign req = '{wr: reg_wr, rd: reg_rd, addr: reg_addr, wdata: reg_wdata};

  // reserved mode codes are kept out of the sequencer
  function automatic logic mode_ok(input logic [2:0] m);
    return m <= 3'h4;
  endfunction

  // address match helper used by write and read decode
  function automatic logic hit(input logic [6:0] a, input logic [6:0] ofs);
    return a == ofs;
  endfunction

  // mode control state
  logic seq_bypass_ff;
  logic listen_en_ff;
  logic [2:0] target_ff;
  logic cancel_ff;

  // modem configuration state
  logic [1:0] dps_ff;
  logic [1:0] mod_ff;
  logic [1:0] shape_ff;
  logic [7:0] rate_hi_ff;
  logic [7:0] rate_lo_ff;

  // side paths toward the packet engine and the sensor
  logic [7:0] fifo_ff;
  logic fifo_wr_ff;
  logic temp_busy_ff;
  logic temp_start_ff;
  logic [7:0] temp_read_ff;

  // test and tuning state
  logic [7:0] boost_ff;
  logic [7:0] hp1_ff;
  logic [7:0] hp2_ff;
  logic [7:0] fade_ff;
  logic [7:0] afc_ff;

  // read path
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic [2:0] cur_mode;
  logic [7:0] key_rdata;
  logic key_hit;
  logic [3:0] key_idx;
  logic [7:0] opmode_img;
  logic [7:0] datamod_img;
  logic [7:0] temp_ctrl_img;

  // cipher key window and the byte index inside it
  assign key_hit = req.addr >= OFS_KEY_FIRST && req.addr <= OFS_KEY_LAST;
  assign key_idx = 4'(req.addr - OFS_KEY_FIRST);

  // mode control register
  // bypass and listen bits land even when the mode code is refused
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      seq_bypass_ff <= 1'b0;
      listen_en_ff <= 1'b0;
      target_ff <= RST_MODE;
    end else if (req.wr && hit(req.addr, OFS_OPMODE)) begin
      seq_bypass_ff <= req.wdata[BIT_SEQ_BYPASS];
      listen_en_ff <= req.wdata[BIT_LISTEN_EN];
      if (mode_ok(req.wdata[POS_MODE_LO +: 3])) begin
        target_ff <= req.wdata[POS_MODE_LO +: 3];
      end
    end
  end

  // listen cancel only counts when listen enable is cleared in the same write
  // cancel is a pulse only, never stored, so its bit reads zero
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      cancel_ff <= 1'b0;
    end else begin
      cancel_ff <= req.wr && hit(req.addr, OFS_OPMODE) && req.wdata[BIT_LISTEN_CANCEL]
                   && !req.wdata[BIT_LISTEN_EN];
    end
  end

  // data and modulation register, unused bits not stored
  // reserved codes are stored as written; software keeps them out
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      dps_ff <= RST_DPS;
      mod_ff <= RST_MOD;
      shape_ff <= RST_SHAPE;
    end else if (req.wr && hit(req.addr, OFS_DATAMOD)) begin
      dps_ff <= req.wdata[POS_DPS_LO +: 2];
      mod_ff <= req.wdata[POS_MOD_LO +: 2];
      shape_ff <= req.wdata[POS_SHAPE_LO +: 2];
    end
  end

  // rate divisor bytes
  // no shadow copy: software writes the high byte, then the low byte
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      rate_hi_ff <= RST_RATE_HI;
      rate_lo_ff <= RST_RATE_LO;
    end else if (req.wr) begin
      if (hit(req.addr, OFS_RATE_HI)) begin
        rate_hi_ff <= req.wdata;
      end else if (hit(req.addr, OFS_RATE_LO)) begin
        rate_lo_ff <= req.wdata;
      end
    end
  end

  // fifo port byte and write pulse toward the packet path
  // the pulse marks a fresh byte on fifo_wr_data
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      fifo_ff <= RST_FIFO_PORT;
      fifo_wr_ff <= 1'b0;
    end else begin
      fifo_wr_ff <= req.wr && hit(req.addr, OFS_FIFO_PORT);
      if (req.wr && hit(req.addr, OFS_FIFO_PORT)) begin
        fifo_ff <= req.wdata;
      end
    end
  end

  // temperature start, busy flag and readout capture; a new start beats done
  // a done that meets a fresh start belongs to the old run, so busy stays set
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      temp_busy_ff <= 1'b0;
      temp_start_ff <= 1'b0;
      temp_read_ff <= 8'h00;
    end else begin
      temp_start_ff <= req.wr && hit(req.addr, OFS_TEMP_CTRL) && req.wdata[BIT_TEMP_START]
                       && !temp_busy_ff;
      if (temp_done) begin
        temp_read_ff <= temp_value;
      end
      if (temp_start_ff) begin
        temp_busy_ff <= 1'b1;
      end else if (temp_done) begin
        temp_busy_ff <= 1'b0;
      end
    end
  end

  // test and tuning registers
  // fade margin resets to zero; software loads its tuned value
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      boost_ff <= RST_SENS_BOOST;
      hp1_ff <= RST_HP_ONE;
      hp2_ff <= RST_HP_TWO;
      fade_ff <= RST_FADE_MARGIN;
      afc_ff <= RST_LOW_IDX_AFC;
    end else if (req.wr) begin
      if (hit(req.addr, OFS_SENS_BOOST)) begin
        boost_ff <= req.wdata;
      end else if (hit(req.addr, OFS_HP_ONE)) begin
        hp1_ff <= req.wdata;
      end else if (hit(req.addr, OFS_HP_TWO)) begin
        hp2_ff <= req.wdata;
      end else if (hit(req.addr, OFS_FADE_MARGIN)) begin
        fade_ff <= req.wdata;
      end else if (hit(req.addr, OFS_LOW_IDX_AFC)) begin
        afc_ff <= req.wdata;
      end
    end
  end

  // cipher key bytes live in their own array
  tmc_key_store #(
    .DEPTH(16)
  ) u_key (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .we(req.wr && key_hit),
    .idx(key_idx),
    .wdata(req.wdata),
    .rdata(key_rdata)
  );

  // operating state walker
  tmc_mode_seq #(
    .STEP_CYC(STEP_CYC)
  ) u_seq (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .bypass(seq_bypass_ff),
    .target(target_ff),
    .cur_mode(cur_mode)
  );

  // register images assembled once, unused bits fixed at zero except temp control bit 0, fixed at one
  assign opmode_img = {seq_bypass_ff, listen_en_ff, 1'b0, cur_mode, 2'b00};
  assign datamod_img = {1'b0, dps_ff, mod_ff, 1'b0, shape_ff};
  assign temp_ctrl_img = {5'h00, 1'b0, temp_busy_ff, 1'b1};

  // read mux; unmapped addresses read zero
  // the key window is one range test, not sixteen decodes
  always_comb begin
    nxt_rdata = 8'h00;
    if (hit(req.addr, OFS_FIFO_PORT)) begin
      nxt_rdata = fifo_ff;
    end else if (hit(req.addr, OFS_OPMODE)) begin
      nxt_rdata = opmode_img;
    end else if (hit(req.addr, OFS_DATAMOD)) begin
      nxt_rdata = datamod_img;
    end else if (hit(req.addr, OFS_RATE_HI)) begin
      nxt_rdata = rate_hi_ff;
    end else if (hit(req.addr, OFS_RATE_LO)) begin
      nxt_rdata = rate_lo_ff;
    end else if (key_hit) begin
      nxt_rdata = key_rdata;
    end else if (hit(req.addr, OFS_TEMP_CTRL)) begin
      nxt_rdata = temp_ctrl_img;
    end else if (hit(req.addr, OFS_TEMP_READ)) begin
      nxt_rdata = temp_read_ff;
    end else if (hit(req.addr, OFS_SENS_BOOST)) begin
      nxt_rdata = boost_ff;
    end else if (hit(req.addr, OFS_HP_ONE)) begin
      nxt_rdata = hp1_ff;
    end else if (hit(req.addr, OFS_HP_TWO)) begin
      nxt_rdata = hp2_ff;
    end else if (hit(req.addr, OFS_FADE_MARGIN)) begin
      nxt_rdata = fade_ff;
    end else if (hit(req.addr, OFS_LOW_IDX_AFC)) begin
      nxt_rdata = afc_ff;
    end
  end

  // read data register, zero outside a read answer
  // zero between answers so a stale byte is never taken for a fresh one
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= req.rd ? nxt_rdata : 8'h00;
    end
  end

  // registered mode outputs
  // op_mode lags cur_mode by one cycle; the read image shows cur_mode itself
  // listen_active follows the stored enable bit, also one cycle late
  logic [2:0] op_mode_ff;
  logic listen_act_ff;
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      op_mode_ff <= RST_MODE;
      listen_act_ff <= 1'b0;
    end else begin
      op_mode_ff <= cur_mode;
      listen_act_ff <= listen_en_ff;
    end
  end

  // register port and mode outputs
  assign reg_rdata = rdata_ff;
  assign op_mode = op_mode_ff;
  assign listen_active = listen_act_ff;
  assign listen_cancel_pulse = cancel_ff;

  // side paths toward the packet engine and the sensor
  assign fifo_wr_data = fifo_ff;
  assign fifo_wr_pulse = fifo_wr_ff;
  assign temp_start_pulse = temp_start_ff;

  // divisor bytes joined high then low; rate = crystal / divisor
  assign modem_cfg = '{
    data_processing_select: dps_ff,
    modulation_select: mod_ff,
    pulse_shaping_select: shape_ff,
    rate_divisor: {rate_hi_ff, rate_lo_ff}
  };

  // test and tuning values
  assign sensitivity_boost = boost_ff;
  assign high_power_setting_one = hp1_ff;
  assign high_power_setting_two = hp2_ff;
  assign fading_margin_control = fade_ff;
  assign low_index_freq_offset = afc_ff;
endmodule

// ---- logic/tmc_pkg.sv ----
// Purpose: shared constants and types for the transceiver mode/config bank
// Assumes: byte-wide register port, 7-bit register index
// Notes: offsets are register indices on the plain port
package tmc_pkg;
  localparam int TMC_AW = 7;
  localparam int TMC_DW = 8;
  // register offsets
  localparam logic [6:0] OFS_FIFO_PORT = 7'h00;
  localparam logic [6:0] OFS_OPMODE = 7'h01;
  localparam logic [6:0] OFS_DATAMOD = 7'h02;
  localparam logic [6:0] OFS_RATE_HI = 7'h03;
  localparam logic [6:0] OFS_RATE_LO = 7'h04;
  localparam logic [6:0] OFS_KEY_FIRST = 7'h3E;
  localparam logic [6:0] OFS_KEY_LAST = 7'h4D;
  localparam logic [6:0] OFS_TEMP_CTRL = 7'h4E;
  localparam logic [6:0] OFS_TEMP_READ = 7'h4F;
  localparam logic [6:0] OFS_SENS_BOOST = 7'h58;
  localparam logic [6:0] OFS_HP_ONE = 7'h5A;
  localparam logic [6:0] OFS_HP_TWO = 7'h5C;
  localparam logic [6:0] OFS_FADE_MARGIN = 7'h6F;
  localparam logic [6:0] OFS_LOW_IDX_AFC = 7'h71;
  // field positions
  localparam int BIT_SEQ_BYPASS = 7;
  localparam int BIT_LISTEN_EN = 6;
  localparam int BIT_LISTEN_CANCEL = 5;
  localparam int POS_MODE_LO = 2;
  localparam int POS_DPS_LO = 5;
  localparam int POS_MOD_LO = 3;
  localparam int POS_SHAPE_LO = 0;
  localparam int BIT_TEMP_START = 3;
  // reset values
  localparam logic [7:0] RST_FIFO_PORT = 8'h00;
  localparam logic [2:0] RST_MODE = 3'h1;
  localparam logic [1:0] RST_DPS = 2'h0;
  localparam logic [1:0] RST_MOD = 2'h0;
  localparam logic [1:0] RST_SHAPE = 2'h0;
  localparam logic [7:0] RST_RATE_HI = 8'h1A;
  localparam logic [7:0] RST_RATE_LO = 8'h0B;
  localparam logic [7:0] RST_KEY = 8'h00;
  localparam logic [7:0] RST_TEMP_CTRL = 8'h01;
  localparam logic [7:0] RST_SENS_BOOST = 8'h1B;
  localparam logic [7:0] RST_HP_ONE = 8'h55;
  localparam logic [7:0] RST_HP_TWO = 8'h70;
  localparam logic [7:0] RST_FADE_MARGIN = 8'h00;
  localparam logic [7:0] RST_LOW_IDX_AFC = 8'h00;
  // timing: one sequencer step between intermediate states
  localparam int SEQ_STEP_NS = 100;
  localparam int CLK_PERIOD_NS = 20;
  localparam int SEQ_STEP_CYC = (SEQ_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // operating mode codes
  typedef enum logic [2:0] {
    TMC_SLEEP = 3'h0,
    TMC_STANDBY = 3'h1,
    TMC_SYNTH = 3'h2,
    TMC_TX = 3'h3,
    TMC_RX = 3'h4
  } tmc_mode_t;

  // register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [6:0] addr;
    logic [7:0] wdata;
  } tmc_req_t;

  // modem configuration carried to the radio datapath
  typedef struct packed {
    logic [1:0] data_processing_select;
    logic [1:0] modulation_select;
    logic [1:0] pulse_shaping_select;
    logic [15:0] rate_divisor;
  } tmc_modem_cfg_t;
endpackage

// ---- logic/tmc_mode_seq.sv ----
// Purpose: walks the operating state toward the commanded mode
// Assumes: target code already checked against reserved codes
// Notes: one intermediate step per SEQ_STEP_CYC cycles
`timescale 1ns/1ps
module tmc_mode_seq
  import tmc_pkg::*;
#(
  parameter int STEP_CYC = SEQ_STEP_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic bypass,
  input wire logic [2:0] target,
  output logic [2:0] cur_mode
);
  initial begin
    if (STEP_CYC < 1 || STEP_CYC > 255) begin
      $error("tmc_mode_seq: STEP_CYC out of range");
    end
  end

  logic [2:0] cur_ff;
  logic [7:0] step_ff;

  // one rung toward the target along sleep-standby-synth-tx/rx
  function automatic logic [2:0] next_rung(input logic [2:0] cur, input logic [2:0] tgt);
    logic [2:0] r;
    r = cur;
    if (cur == 3'h0) begin
      r = 3'h1;
    end else if (tgt == 3'h0) begin
      r = (cur == 3'h1) ? 3'h0 : ((cur == 3'h2) ? 3'h1 : 3'h2);
    end else if (cur == 3'h1) begin
      r = 3'h2;
    end else if (cur == 3'h2) begin
      r = (tgt == 3'h1) ? 3'h1 : tgt;
    end else begin
      r = 3'h2;
    end
    return r;
  endfunction

  // step pacing counter
  always_ff @(posedge clk_sys) begin
    if (!rst_b || bypass || cur_ff == target || step_ff == 8'(STEP_CYC - 1)) begin
      step_ff <= 8'h00;
    end else begin
      step_ff <= step_ff + 8'h01;
    end
  end

  // operating state
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      cur_ff <= RST_MODE;
    end else if (bypass) begin
      cur_ff <= target;
    end else if (cur_ff != target && step_ff == 8'(STEP_CYC - 1)) begin
      cur_ff <= next_rung(cur_ff, target);
    end
  end

  assign cur_mode = cur_ff;
endmodule

// ---- logic/tmc_key_store.sv ----
// Purpose: sixteen-byte cipher key storage
// Assumes: index decoded by the bank
// Notes: combinational read of the selected byte
`timescale 1ns/1ps
module tmc_key_store
  import tmc_pkg::*;
#(
  parameter int DEPTH = 16
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic we,
  input wire logic [3:0] idx,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);
  initial begin
    if (DEPTH < 1 || DEPTH > 16) begin
      $error("tmc_key_store: DEPTH out of range");
    end
  end

  logic [7:0] key_ff [DEPTH];

  // key byte array, one flop group per byte
  for (genvar g = 0; g < DEPTH; g++) begin : g_key
    always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
        key_ff[g] <= RST_KEY;
      end else if (we && idx == 4'(g)) begin
        key_ff[g] <= wdata;
      end
    end
  end

  assign rdata = (int'(idx) < DEPTH) ? key_ff[idx] : 8'h00;
endmodule

// ---- test/tmc_config_bank_sva.sv ----
// Purpose: port-level checks for the mode/config bank
// Assumes: one-cycle strobes, read data one cycle after the strobe
// Notes: bound onto every bank instance
`timescale 1ns/1ps
module tmc_config_bank_sva
  import tmc_pkg::*;
#(
  parameter int STEP_CYC = SEQ_STEP_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [6:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [2:0] op_mode,
  input wire logic listen_cancel_pulse,
  input wire tmc_modem_cfg_t modem_cfg
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // decoded strobes
  wire logic wr_op = reg_wr && reg_addr == OFS_OPMODE;
  wire logic rd_op = reg_rd && reg_addr == OFS_OPMODE;
  wire logic wr_dm = reg_wr && reg_addr == OFS_DATAMOD;
  wire logic rd_dm = reg_rd && reg_addr == OFS_DATAMOD;
  wire logic wr_hi = reg_wr && reg_addr == OFS_RATE_HI;
  property p_cancel_pulse;
    wr_op && reg_wdata[5] && !reg_wdata[6] |=> listen_cancel_pulse;
  endproperty
  a_cancel_pulse: assert property (p_cancel_pulse) else $error("no cancel pulse");
  property p_cancel_cause;
    listen_cancel_pulse |-> $past(wr_op && reg_wdata[5] && !reg_wdata[6]);
  endproperty
  a_cancel_cause: assert property (p_cancel_cause) else $error("stray cancel");
  property p_op_unused;
    rd_op |=> reg_rdata[1:0] == 2'h0 && !reg_rdata[5];
  endproperty
  a_op_unused: assert property (p_op_unused) else $error("mode reg bits");
  property p_dm_unused;
    rd_dm |=> !reg_rdata[7] && !reg_rdata[2];
  endproperty
  a_dm_unused: assert property (p_dm_unused) else $error("modul reg bits");
  property p_rate_hi;
    wr_hi |=> modem_cfg.rate_divisor[15:8] == $past(reg_wdata);
  endproperty
  a_rate_hi: assert property (p_rate_hi) else $error("rate high byte");
  property p_dm_fields;
    wr_dm |=> {modem_cfg.data_processing_select, modem_cfg.modulation_select,
      modem_cfg.pulse_shaping_select} == $past({reg_wdata[6:3], reg_wdata[1:0]});
  endproperty
  a_dm_fields: assert property (p_dm_fields) else $error("modul fields");
  property p_mode_range;
    op_mode <= 3'h4;
  endproperty
  a_mode_range: assert property (p_mode_range) else $error("reserved mode");
  property p_reset;
    $rose(rst_b) |-> op_mode == 3'h1 && modem_cfg.rate_divisor == 16'h1A0B;
  endproperty
  a_reset: assert property (p_reset) else $error("reset values");
  property p_bypass;
    wr_op && reg_wdata[7] && reg_wdata[4:2] <= 3'h4 ##1 !wr_op
      |-> ##2 op_mode == $past(reg_wdata[4:2], 3);
  endproperty
  a_bypass: assert property (p_bypass) else $error("forced mode");
  property p_readback;
    rd_op |=> reg_rdata[4:2] == op_mode;
  endproperty
  a_readback: assert property (p_readback) else $error("mode readback");
  // main scenarios seen
  c_cancel: cover property (wr_op ##1 listen_cancel_pulse);
  c_tx: cover property (op_mode == 3'h3);
  c_ook: cover property (wr_dm ##1 modem_cfg.modulation_select == 2'h1);
endmodule
bind tmc_config_bank tmc_config_bank_sva #(.STEP_CYC(STEP_CYC)) u_sva (.clk_sys, .rst_b,
  .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .op_mode, .listen_cancel_pulse,
  .modem_cfg);

// ---- test/test_transceiver_mode_config_regs.sv ----
// Purpose: self-checking bench for the mode/config bank
// Assumes: sequencer step shortened to 2 cycles
// Notes: mdl holds the expected byte of every index
`timescale 1ns/1ps
module test_transceiver_mode_config_regs;
  import tmc_pkg::*;
  logic clk_sys, rst_b, reg_wr, reg_rd, temp_done, lis, cxl, fpul, tpul;
  logic [6:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, temp_value, fdat, boost, hp1, hp2, fade, afc, rv, d;
  logic [2:0] op_mode;
  tmc_modem_cfg_t cfg;
  logic [7:0] mdl [128];
  int miscompares, cmp_count, cur, n;
  int tg [4] = '{3, 4, 0, 4};
  tmc_config_bank #(.STEP_CYC(2)) dut (.clk_sys(clk_sys), .rst_b(rst_b),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .temp_value(temp_value), .temp_done(temp_done), .reg_rdata(reg_rdata),
    .op_mode(op_mode), .listen_active(lis), .listen_cancel_pulse(cxl),
    .fifo_wr_data(fdat), .fifo_wr_pulse(fpul), .temp_start_pulse(tpul),
    .modem_cfg(cfg), .sensitivity_boost(boost), .high_power_setting_one(hp1),
    .high_power_setting_two(hp2), .fading_margin_control(fade),
    .low_index_freq_offset(afc));
  // 50 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // one-cycle write, returns just after the taking edge
  task automatic wr(input logic [6:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    mdl[a] = v;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rc(input logic [6:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk($sformatf("reg %0h", a), reg_rdata, e);
  endtask
  // reset plus fresh expected map
  task automatic do_reset();
    @(posedge clk_sys);
    rst_b <= 1'b0;
    repeat (10) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    foreach (mdl[i]) mdl[i] = 8'h00;
    mdl[1] = 8'h04;
    mdl[3] = 8'h1A;
    mdl[4] = 8'h0B;
    mdl[7'h4E] = 8'h01;
    mdl[7'h58] = 8'h1B;
    mdl[7'h5A] = 8'h55;
    mdl[7'h5C] = 8'h70;
  endtask
  task automatic all_regs(input string t);
    for (int a = 1; a < 128; a++) rc(a[6:0], mdl[a]);
    chk("rate", cfg.rate_divisor, {mdl[3], mdl[4]});
    chk("boost", boost, mdl[7'h58]);
    chk("hp1", hp1, mdl[7'h5A]);
    chk("hp2", hp2, mdl[7'h5C]);
    chk("afc", afc, mdl[7'h71]);
    $display("test %s done", t);
  endtask
  // next rung toward the target
  function automatic int step(int c, int t);
    if (c == 0) return 1;
    if (c == 1) return (t == 0) ? 0 : 2;
    if (c == 2) return (t <= 1) ? 1 : t;
    return 2;
  endfunction
  initial begin
    rst_b = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 7'h00;
    reg_wdata = 8'h00;
    temp_value = 8'h00;
    temp_done = 1'b0;
    void'($urandom(45));
    do_reset();
    all_regs("reset");
    foreach (mdl[a]) if (a inside {3, 4, 7'h58, 7'h5A, 7'h5C, 7'h71, [7'h3E:7'h4D]})
      wr(a[6:0], 8'($urandom));
    all_regs("read write");
    wr(7'h6F, 8'h30);
    chk("fade", fade, 8'h30);
    for (int m = 0; m < 32; m++) begin
      if (m[1:0] == 2'h1 || (m[4] && m[3:2] == 2'h3)) continue;
      d = {1'($urandom), m[1:0], 1'b0, m[4], 1'($urandom), m[3:2]};
      wr(OFS_DATAMOD, d);
      chk("modul", {cfg.data_processing_select, cfg.modulation_select,
        cfg.pulse_shaping_select}, {d[6:3], d[1:0]});
      rc(OFS_DATAMOD, d & 8'h7B);
    end
    $display("test modulation done");
    for (int m = 4; m >= 0; m--) begin
      wr(OFS_OPMODE, {3'b100, 3'(m), 2'($urandom)});
      repeat (2) @(posedge clk_sys);
      #1;
      chk("op_mode", op_mode, m);
      rc(OFS_OPMODE, {3'b100, 3'(m), 2'b00});
    end
    wr(OFS_OPMODE, 8'h84);
    wr(OFS_OPMODE, 8'hC4);
    @(posedge clk_sys);
    #1;
    chk("listen", lis, 1'b1);
    wr(OFS_OPMODE, 8'hE4);
    chk("cancel", cxl, 1'b0);
    rc(OFS_OPMODE, 8'hC4);
    wr(OFS_OPMODE, 8'hA4);
    chk("cancel", cxl, 1'b1);
    @(posedge clk_sys);
    #1;
    chk("cancel", cxl, 1'b0);
    chk("listen", lis, 1'b0);
    $display("test listen done");
    cur = 1;
    foreach (tg[i]) begin
      wr(OFS_OPMODE, {3'b000, 3'(tg[i]), 2'b00});
      for (n = 0; n < 60 && cur != tg[i]; n++) begin
        @(posedge clk_sys);
        #1;
        if (op_mode !== 3'(cur)) begin
          cur = step(cur, tg[i]);
          chk("walk", op_mode, cur);
        end
      end
      if (cur != tg[i]) begin
        miscompares++;
        results();
      end
      rc(OFS_OPMODE, {3'b000, 3'(tg[i]), 2'b00});
    end
    $display("test sequencer done");
    rv = 8'($urandom);
    wr(OFS_FIFO_PORT, rv);
    chk("fifo", {fpul, fdat}, {1'b1, rv});
    wr(OFS_TEMP_CTRL, 8'h08);
    chk("temp start", tpul, 1'b1);
    @(posedge clk_sys);
    temp_value <= rv ^ 8'h5A;
    temp_done <= 1'b1;
    @(posedge clk_sys);
    temp_done <= 1'b0;
    rc(OFS_TEMP_READ, rv ^ 8'h5A);
    do_reset();
    all_regs("second reset");
    results();
  end
endmodule
